// >>> hw/sdcd_device.sv
// sdcd_device: command decode and mask front end of a four-bank dram
// assumes: all link inputs come from logic on clk; write data leaves
// through an 8-deep fifo to the array side, read data enters from it
`timescale 1ns/100ps
module sdcd_device #(
   parameter int ROW_W = 13
) (
   input  wire logic                          clk,
   input  wire logic                          rst,
   sdcd_link_if.dev                           link,
   output logic [sdcd_pkg::BANKS-1:0]         bankOpen,      // open row per bank
   output logic [sdcd_pkg::OPC_W-1:0]         modeOpcode,    // stored op-code
   output logic [ROW_W-1:0]                   refreshRow,    // refresh counter
   output logic                               selfRefresh,   // in self refresh
   output logic                               deep_sleep_mode, // in deep sleep
   output logic                               wrValid,       // write beat to array
   output logic [sdcd_pkg::DATA_W-1:0]        wrData,
   output logic [sdcd_pkg::MASK_W-1:0]        wrMask,
   output logic [sdcd_pkg::COL_W-1:0]         wrCol,
   input  wire logic                          wrReady,       // array accepts beat
   input  wire logic [sdcd_pkg::DATA_W-1:0]   rdData,        // array read word
   output logic                               rdActive,      // read beat this cycle
   output logic [sdcd_pkg::COL_W-1:0]         rdCol          // read column
);
   localparam int CW = sdcd_pkg::COL_W;
   localparam int LW = sdcd_pkg::MASK_RD_LAT;
   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   sdcd_pkg::sdcd_cmd_t cmd;
   logic isAct, isRd, isWr, isPre, isRef, isMld, isTerm, live;
   logic [1:0] bank;
   always_comb begin
      cmd    = sdcd_pkg::sdcd_cmd_t'({link.rowStbN, link.colStbN, link.wrStbN});
      live   = !link.selN && !selfRefresh && !deep_sleep_mode;
      bank   = {link.bank_sel_hi, link.bank_sel_lo};
      isAct  = live && link.clkGate && cmd == sdcd_pkg::SDCD_ACT;
      isRd   = live && link.clkGate && cmd == sdcd_pkg::SDCD_RD;
      isWr   = live && link.clkGate && cmd == sdcd_pkg::SDCD_WR;
      isPre  = live && link.clkGate && cmd == sdcd_pkg::SDCD_PRE;
      isRef  = live && cmd == sdcd_pkg::SDCD_REF;
      isMld  = live && link.clkGate && cmd == sdcd_pkg::SDCD_MLD && bankOpen == '0;
      isTerm = live && cmd == sdcd_pkg::SDCD_TERM;
   end
   // ------------------------------------------------------------
   // burst state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SDCD_IDLE = 3'b001,
      SDCD_READ = 3'b010,
      SDCD_WRIT = 3'b100
   } sdcd_burst_t;
   sdcd_burst_t st, next_st;
   logic [CW-1:0] base, next_base, idx, next_idx;
   logic [CW-1:0] len, col, next_rdCol;
   logic [1:0] bBank, next_bBank;
   logic bAp, next_bAp, last;
   logic [sdcd_pkg::BANKS-1:0] next_open;
   logic [sdcd_pkg::OPC_W-1:0] next_mode;
   logic [ROW_W-1:0] next_refRow;
   logic next_self, next_deep, next_rdActive;
   logic [LW*sdcd_pkg::MASK_W-1:0] mPipe, next_mPipe;
   logic [LW-1:0] aPipe, next_aPipe;
   logic fInValid, fInReady;
   logic [sdcd_pkg::DATA_W+sdcd_pkg::MASK_W+CW-1:0] fOut;
   logic wrGo;
   always_comb begin
      // burst length from op-code: 1,2,4,8 or full page
      len = (modeOpcode[sdcd_pkg::BL_LSB +: sdcd_pkg::BL_W] == sdcd_pkg::BL_FULL) ? '1 :
            CW'(1 << modeOpcode[sdcd_pkg::BL_LSB +: 2]);
      // interleaved order flips low bits, sequential adds
      if (modeOpcode[sdcd_pkg::BT_BIT]) begin
         col = base ^ idx;
      end else begin
         col = (base & ~CW'(len - 1'b1)) | CW'((base + idx) & CW'(len - 1'b1));
      end
      last = (idx == CW'(len - 1'b1)) && (len != '1);  // full page never ends
   end
   // ------------------------------------------------------------
   // next state of the command engine
   // ------------------------------------------------------------
   always_comb begin
      next_st     = st;
      next_base   = base;
      next_idx    = CW'(idx + 1'b1);
      next_bBank  = bBank;
      next_bAp    = bAp;
      next_open   = bankOpen;
      next_mode   = modeOpcode;
      next_refRow = refreshRow;
      next_self   = selfRefresh;
      next_deep   = deep_sleep_mode;
      if (st != SDCD_IDLE && last) begin
         next_st = SDCD_IDLE;
         if (bAp) begin
            next_open[bBank] = 1'b0;
         end
      end
      if (st == SDCD_IDLE) begin
         next_idx = '0;
      end
      // leave low-power states when the gate rises
      if ((selfRefresh || deep_sleep_mode) && link.clkGate) begin
         next_self = 1'b0;
         next_deep = 1'b0;
      end
      if (isAct) begin
         next_open[bank] = 1'b1;
      end
      if (isRd || isWr) begin
         // new column each cycle restarts the burst
         next_st    = isRd ? SDCD_READ : SDCD_WRIT;
         next_base  = link.addr[CW-1:0];
         next_idx   = '0;
         next_bBank = bank;
         next_bAp   = link.addr[sdcd_pkg::AP_BIT];
         // write beat zero rides with the command, so the burst goes on at one
         if (isWr) begin
            next_idx = CW'(1'b1);
            if (len == CW'(1'b1)) begin
               next_st = SDCD_IDLE;                     // single beat already taken
            end
         end
      end
      if (isPre) begin
         // a burst in another bank keeps going unless the all-banks bit is set
         if (link.addr[sdcd_pkg::AP_BIT]) begin
            next_open = '0;
         end else begin
            next_open[bank] = 1'b0;
         end
         if (link.addr[sdcd_pkg::AP_BIT] || bank == bBank) begin
            next_st = SDCD_IDLE;
         end
      end
      if (isRef) begin
         next_refRow = ROW_W'(refreshRow + 1'b1);
         next_self   = !link.clkGate;
      end
      if (isMld) begin
         next_mode = link.addr[sdcd_pkg::OPC_W-1:0];
      end
      if (isTerm) begin
         if (link.clkGate) begin
            next_st = SDCD_IDLE;
         end else if (bankOpen == '0) begin
            next_deep = 1'b1;
         end
      end
      next_rdActive = (next_st == SDCD_READ);
      next_rdCol    = (isRd) ? link.addr[CW-1:0] : col;
      // read mask pipe, two stages
      next_mPipe = {mPipe[0 +: (LW-1)*sdcd_pkg::MASK_W], link.mask};
      next_aPipe = {aPipe[0 +: LW-1], rdActive};
   end
   // registers of the command engine, sampled on rising edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st              <= SDCD_IDLE;
         base            <= '0;
         idx             <= '0;
         bBank           <= '0;
         bAp             <= 1'b0;
         bankOpen        <= '0;
         modeOpcode      <= sdcd_pkg::MODE_RST;
         refreshRow      <= '0;
         selfRefresh     <= 1'b0;
         deep_sleep_mode <= 1'b0;
         rdActive        <= 1'b0;
         rdCol           <= '0;
         mPipe           <= '0;
         aPipe           <= '0;
      end else begin
         st              <= next_st;
         base            <= next_base;
         idx             <= next_idx;
         bBank           <= next_bBank;
         bAp             <= next_bAp;
         bankOpen        <= next_open;
         modeOpcode      <= next_mode;
         refreshRow      <= next_refRow;
         selfRefresh     <= next_self;
         deep_sleep_mode <= next_deep;
         rdActive        <= next_rdActive;
         rdCol           <= next_rdCol;
         mPipe           <= next_mPipe;
         aPipe           <= next_aPipe;
      end
   end
   // ------------------------------------------------------------
   // write path: mask taken with the data, same cycle
   // ------------------------------------------------------------
   always_comb begin
      wrGo     = (isWr || st == SDCD_WRIT) && !isTerm && !isPre;
      fInValid = wrGo && (link.mask != '1);  // fully masked beat dropped
   end
   // limitation: a full fifo drops beats; size it above the array stall
   sdcd_fifo #(
      .WIDTH (sdcd_pkg::DATA_W + sdcd_pkg::MASK_W + CW),
      .DEPTH (sdcd_pkg::FIFO_D)
   ) uFifo (
      .clk      (clk),
      .rst      (rst),
      .inValid  (fInValid),
      .inReady  (fInReady),
      .inData   ({link.dqIn, link.mask, (isWr ? link.addr[CW-1:0] : col)}),
      .outValid (wrValid),
      .outReady (wrReady),
      .outData  (fOut)
   );
   assign {wrData, wrMask, wrCol} = fOut;
   // ------------------------------------------------------------
   // read drive: per byte, gated by mask two clocks old
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link.devDq   <= '0;
         link.devDqOe <= '0;
      end else begin
         link.devDq   <= rdData;
         link.devDqOe <= {sdcd_pkg::MASK_W{aPipe[0]}} &
                         ~mPipe[(LW-1)*sdcd_pkg::MASK_W +: sdcd_pkg::MASK_W];
      end
   end
endmodule

// >>> hw/sdcd_pkg.sv
// sdcd_pkg: shared constants for the command decode front end
// assumes: both ends and the link carrier compile after this package
package sdcd_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int ADDR_W   = 13;           // row / column address width
   localparam int DATA_W   = 16;           // data bus width
   localparam int MASK_W   = 2;            // one mask bit per byte
   localparam int BANKS    = 4;            // four banks
   localparam int OPC_W    = 12;           // mode op-code width
   localparam int COL_W    = 9;            // column address width
   localparam int FIFO_D   = 8;            // fifo depth
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int AP_BIT   = 10;           // auto precharge / all-banks bit
   localparam int BL_LSB   = 0;            // burst length code in op-code
   localparam int BL_W     = 3;
   localparam int BT_BIT   = 3;            // burst type: 1 = interleaved
   // ------------------------------------------------------------
   // timing and codes
   // ------------------------------------------------------------
   localparam int MASK_RD_LAT   = 2;       // read mask to high-z, clocks
   localparam int MODE_LOAD_DLY = 2;       // mode load delay, clocks
   localparam logic [2:0] BL_FULL = 3'h7;  // full page burst code
   localparam logic [OPC_W-1:0] MODE_RST = 12'h000;
   localparam logic [3:0] ROWS_ONES = 4'hF;
   // command codes: {ras, cas, we} with select low
   typedef enum logic [2:0] {
      SDCD_ACT  = 3'h3,
      SDCD_RD   = 3'h5,
      SDCD_WR   = 3'h4,
      SDCD_NOP  = 3'h7,
      SDCD_PRE  = 3'h2,
      SDCD_REF  = 3'h1,
      SDCD_MLD  = 3'h0,
      SDCD_TERM = 3'h6
   } sdcd_cmd_t;
endpackage

// >>> hw/sdcd_link_if.sv
// sdcd_link_if: pins between memory controller and device
// assumes: one common clock; the bench resolves the data wire
`timescale 1ns/100ps
interface sdcd_link_if;
   logic                           selN;        // chip select, low active
   logic                           rowStbN;     // row strobe
   logic                           colStbN;     // column strobe
   logic                           wrStbN;      // write strobe
   logic                           clkGate;     // clock gate
   logic                           bank_sel_lo; // bank select bits
   logic                           bank_sel_hi;
   logic [sdcd_pkg::ADDR_W-1:0]    addr;        // address
   logic [sdcd_pkg::MASK_W-1:0]    mask;        // byte masks
   logic [sdcd_pkg::DATA_W-1:0]    ctlDq;       // controller drive value
   logic                           ctlDqOe;     // controller drives data
   logic [sdcd_pkg::DATA_W-1:0]    devDq;       // device drive value
   logic [sdcd_pkg::MASK_W-1:0]    devDqOe;     // device drives, per byte
   logic [sdcd_pkg::DATA_W-1:0]    dqIn;        // resolved wire level
   modport ctl (output selN, rowStbN, colStbN, wrStbN, clkGate, bank_sel_lo,
                bank_sel_hi, addr, mask, ctlDq, ctlDqOe, input dqIn);
   modport dev (input selN, rowStbN, colStbN, wrStbN, clkGate, bank_sel_lo,
                bank_sel_hi, addr, mask, dqIn, output devDq, devDqOe);
endinterface

// >>> hw/sdcd_fifo.sv
// sdcd_fifo: small valid/ready fifo for the data path
// assumes: one clock, async high reset
`timescale 1ns/100ps
module sdcd_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];      // storage
   logic [AW-1:0]    wp, rp, next_wp, next_rp;
   logic [AW:0]      cnt, next_cnt;    // fill level
   logic             push, pop;
   // ------------------------------------------------------------
   // next pointers
   // ------------------------------------------------------------
   always_comb begin
      push     = inValid && inReady;
      pop      = outValid && outReady;
      next_wp  = push ? AW'(wp + 1'b1) : wp;
      next_rp  = pop ? AW'(rp + 1'b1) : rp;
      next_cnt = (AW+1)'(cnt + push - pop);
   end
   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end
   // storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= inData;
      end
   end
   assign inReady  = (cnt != (AW+1)'(DEPTH));  // honest full
   assign outValid = (cnt != '0);
   assign outData  = mem[rp];
endmodule

// >>> hw/sdcd_ctrl.sv
// sdcd_ctrl: controller end, turns user requests into pin commands
// assumes: one clock; user holds reqValid until reqReady
`timescale 1ns/100ps
module sdcd_ctrl (
   input  wire logic                        clk,
   input  wire logic                        rst,
   sdcd_link_if.ctl                         link,
   input  wire logic                        reqValid,  // command request
   input  wire logic [2:0]                  reqCmd,    // sdcd_cmd_t code
   input  wire logic                        reqGate,   // clock gate level
   input  wire logic [1:0]                  reqBank,
   input  wire logic [sdcd_pkg::ADDR_W-1:0] reqAddr,
   input  wire logic [sdcd_pkg::MASK_W-1:0] reqMask,
   input  wire logic [sdcd_pkg::DATA_W-1:0] reqData,
   input  wire logic                        reqDrive,  // drive data this cycle
   output logic                             reqReady,  // request taken
   output logic [sdcd_pkg::DATA_W-1:0]      rdWord     // bus sampled each clock
);
   logic [1:0] wait_q, next_wait;   // mode load delay counter
   logic       sleep, next_sleep;   // self refresh or deep sleep held
   logic       take;
   // ------------------------------------------------------------
   // acceptance and pacing
   // ------------------------------------------------------------
   always_comb begin
      take       = reqValid && (wait_q == '0);
      next_wait  = (wait_q != '0) ? 2'(wait_q - 1'b1) : 2'h0;
      next_sleep = sleep;
      if (take && reqCmd == sdcd_pkg::SDCD_MLD) begin
         next_wait = 2'(sdcd_pkg::MODE_LOAD_DLY - 1);
      end
      // self refresh and deep sleep both need the gate held low until exit
      if (take && !reqGate && (reqCmd == sdcd_pkg::SDCD_REF ||
                               reqCmd == sdcd_pkg::SDCD_TERM)) begin
         next_sleep = 1'b1;
      end else if (take && sleep && reqGate) begin
         next_sleep = 1'b0;
      end
   end
   // pin registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q           <= '0;
         sleep            <= 1'b0;
         reqReady         <= 1'b0;
         link.selN        <= 1'b1;
         link.rowStbN     <= 1'b1;
         link.colStbN     <= 1'b1;
         link.wrStbN      <= 1'b1;
         link.clkGate     <= 1'b1;
         link.bank_sel_lo <= 1'b0;
         link.bank_sel_hi <= 1'b0;
         link.addr        <= '0;
         link.mask        <= '0;
         link.ctlDq       <= '0;
         link.ctlDqOe     <= 1'b0;
         rdWord           <= '0;
      end else begin
         wait_q           <= next_wait;
         sleep            <= next_sleep;
         reqReady         <= take;
         link.selN        <= !take;
         {link.rowStbN, link.colStbN, link.wrStbN} <= take ? reqCmd : 3'h7;
         // gate follows reqGate on a taken request, else stays low while sleep holds
         link.clkGate     <= take ? reqGate : !next_sleep;
         link.bank_sel_lo <= reqBank[0];
         link.bank_sel_hi <= reqBank[1];
         link.addr        <= reqAddr;
         link.mask        <= reqMask;
         link.ctlDq       <= reqData;
         link.ctlDqOe     <= reqDrive;
         rdWord           <= link.dqIn;
      end
   end
endmodule

// >>> test/sdcd_checker.sv
// sdcd_checker: timing relations on the controller/device link
// assumes: one clock, async high reset, sees link pins and device state
`timescale 1ns/100ps
module sdcd_checker (
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic                        selN,
   input wire logic                        rowStbN,
   input wire logic                        colStbN,
   input wire logic                        wrStbN,
   input wire logic                        clkGate,
   input wire logic                        bank_sel_lo,
   input wire logic                        bank_sel_hi,
   input wire logic [sdcd_pkg::ADDR_W-1:0] addr,
   input wire logic [sdcd_pkg::MASK_W-1:0] mask,
   input wire logic [sdcd_pkg::MASK_W-1:0] devDqOe,
   input wire logic [3:0]                  bankOpen,
   input wire logic [11:0]                 modeOpcode
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic [2:0] cmd;          // strobe levels as one code
   logic [1:0] bk;           // bank index
   logic       live;         // selected, gate high
   logic       rdwr;         // column access this cycle
   logic [1:0] apBank;       // bank of last column access
   logic [1:0] next_apBank;
   assign cmd  = {rowStbN, colStbN, wrStbN};
   assign bk   = {bank_sel_hi, bank_sel_lo};
   assign live = !selN && clkGate;
   assign rdwr = live && (cmd == sdcd_pkg::SDCD_RD || cmd == sdcd_pkg::SDCD_WR);
   // remember the bank so an auto close can be traced later
   always_comb begin
      next_apBank = rdwr ? bk : apBank;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         apBank <= 2'h0;
      end else begin
         apBank <= next_apBank;
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_act_opens: assert property (live && cmd == sdcd_pkg::SDCD_ACT |=> bankOpen[$past(bk)])
      else $error("activate left the bank closed");
   a_no_new_open: assert property ($past(selN) |-> (bankOpen & ~$past(bankOpen)) == 4'h0)
      else $error("bank opened while deselected");
   a_pre_one: assert property (live && cmd == sdcd_pkg::SDCD_PRE && !addr[10]
      |=> bankOpen == ($past(bankOpen) & ~(4'h1 << $past(bk))))
      else $error("single precharge hit wrong banks");
   a_pre_all: assert property (live && cmd == sdcd_pkg::SDCD_PRE && addr[10] |=> bankOpen == 4'h0)
      else $error("all-bank precharge left a bank open");
   a_mode_store: assert property (live && cmd == sdcd_pkg::SDCD_MLD && bankOpen == 4'h0
      |=> modeOpcode == $past(addr[11:0]))
      else $error("op-code not stored");
   a_mode_gap: assert property (live && cmd == sdcd_pkg::SDCD_MLD |=> selN || cmd == sdcd_pkg::SDCD_NOP)
      else $error("command too soon after mode load");
   a_rd_drive: assert property (rdwr && cmd == sdcd_pkg::SDCD_RD && mask == 2'h0 |-> ##3 devDqOe == 2'h3)
      else $error("unmasked read data not driven");
   a_mask_hiz: assert property ((devDqOe & $past(mask, 3)) == 2'h0)
      else $error("masked byte driven");
   a_gate_low: assert property ($fell(clkGate) |-> !selN && (cmd == sdcd_pkg::SDCD_REF
      || cmd == sdcd_pkg::SDCD_TERM))
      else $error("gate dropped on a normal command");
   a_ap_close: assert property (rdwr && addr[10] |-> ##[1:8] !bankOpen[apBank])
      else $error("auto precharge never closed the row");
   c_read: cover property (rdwr && cmd == sdcd_pkg::SDCD_RD && mask == 2'h0);
   c_sleep: cover property ($fell(clkGate));
   c_mode: cover property (live && cmd == sdcd_pkg::SDCD_MLD);
endmodule

// >>> test/sdram_command_decode_tb_top.sv
// sdram_command_decode_tb_top: controller and device joined by the link
// assumes: both ends and the link carrier compiled before this file
`timescale 1ns/100ps
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin failCount++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sdram_command_decode_tb_top;
   localparam int WATCH_CYC = 6000;  // far above the 170 or so needed
   logic        clk, rst, reqValid, reqGate, reqDrive, reqReady, wrReady, wrValid, rdActive;
   logic        selfRefresh, deep_sleep_mode;
   logic [2:0]  reqCmd;
   logic [1:0]  reqBank, reqMask, wrMask, m;
   logic [12:0] reqAddr, refreshRow, oldRow;
   logic [15:0] reqData, rdWord, wrData, rdData, idlePat;
   logic [3:0]  bankOpen;
   logic [11:0] modeOpcode, op;
   logic [8:0]  wrCol, rdCol, col;
   logic [31:0] rng, r;
   logic [26:0] qd[$];       // expected fifo beats {col, mask, data}
   logic [26:0] e;
   int          failCount, nChecks, i;
   sdcd_link_if link ();
   sdcd_ctrl u_sdcd_ctrl (.clk(clk), .rst(rst), .link(link), .reqValid(reqValid),
      .reqCmd(reqCmd), .reqGate(reqGate), .reqBank(reqBank), .reqAddr(reqAddr),
      .reqMask(reqMask), .reqData(reqData), .reqDrive(reqDrive), .reqReady(reqReady),
      .rdWord(rdWord));
   sdcd_device u_sdcd_device (.clk(clk), .rst(rst), .link(link), .bankOpen(bankOpen),
      .modeOpcode(modeOpcode), .refreshRow(refreshRow), .selfRefresh(selfRefresh),
      .deep_sleep_mode(deep_sleep_mode), .wrValid(wrValid), .wrData(wrData), .wrMask(wrMask),
      .wrCol(wrCol), .wrReady(wrReady), .rdData(rdData), .rdActive(rdActive), .rdCol(rdCol));
   sdcd_checker u_sdcd_checker (.clk(clk), .rst(rst), .selN(link.selN), .rowStbN(link.rowStbN),
      .colStbN(link.colStbN), .wrStbN(link.wrStbN), .clkGate(link.clkGate),
      .bank_sel_lo(link.bank_sel_lo), .bank_sel_hi(link.bank_sel_hi), .addr(link.addr),
      .mask(link.mask), .devDqOe(link.devDqOe), .bankOpen(bankOpen), .modeOpcode(modeOpcode));
   // ------------------------------------------------------------
   // wire resolution and array stand-in
   // ------------------------------------------------------------
   // an undriven byte shows a toggling pattern, never a stale value
   assign link.dqIn = {link.ctlDqOe ? link.ctlDq[15:8] : link.devDqOe[1] ? link.devDq[15:8] : idlePat[15:8],
                       link.ctlDqOe ? link.ctlDq[7:0] : link.devDqOe[0] ? link.devDq[7:0] : idlePat[7:0]};
   always #12.5 clk = ~clk;
   always @(posedge clk) idlePat <= ~idlePat;
   always @(negedge clk) rdData <= colWord(rdCol);
   function automatic logic [15:0] colWord(input logic [8:0] c);
      return {c[8:1] ^ 8'h5A, c[7:0]};
   endfunction
   function automatic logic [15:0] keep(input logic [1:0] k);
      return {{8{~k[1]}}, {8{~k[0]}}};
   endfunction
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // one request, held until the controller reports it taken
   task automatic req(input logic [2:0] c, input logic g, input logic [1:0] b,
                      input logic [12:0] a, input logic [1:0] k, input logic [15:0] d);
      int n;
      @(negedge clk);
      reqValid = 1'b1; reqCmd = c; reqGate = g; reqBank = b;
      reqAddr = a; reqMask = k; reqData = d; reqDrive = (c == sdcd_pkg::SDCD_WR);
      for (n = 0; n < 10 && reqReady !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      `CHK(reqReady, 1'b1)
      @(negedge clk);
      reqValid = 1'b0;
      reqDrive = 1'b0;
      @(negedge clk);   // device acts on the pins one edge after the take
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #(25 * WATCH_CYC);
      failCount++;
      complete_run;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0; rst = 1'b1; reqValid = 1'b0; reqCmd = 3'h7; reqGate = 1'b1; reqBank = 2'h0;
      reqAddr = 13'h0000; reqMask = 2'h0; reqData = 16'h0000; reqDrive = 1'b0; wrReady = 1'b0;
      rdData = 16'h0000; idlePat = 16'hA5A5; rng = 32'h000031B4; failCount = 0; nChecks = 0;
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      r = xs();
      op = {r[11:3], 3'h0};     // burst of one keeps beats traceable
      req(sdcd_pkg::SDCD_MLD, 1'b1, 2'h0, {1'b0, op}, 2'h0, 16'h0000);
      `CHK(modeOpcode, op)
      for (i = 0; i < 4; i++) begin
         r = xs();
         req(sdcd_pkg::SDCD_ACT, 1'b1, i[1:0], r[12:0], 2'h0, 16'h0000);
         `CHK(bankOpen[i], 1'b1)
      end
      req(sdcd_pkg::SDCD_MLD, 1'b1, 2'h0, 13'h0FFF, 2'h0, 16'h0000);
      `CHK(modeOpcode, op)
      $display("test mode and activate done");
      for (i = 0; i < 6; i++) begin
         r = xs();
         m = (i == 0) ? 2'h0 : r[17:16];
         col = r[8:0];
         req(sdcd_pkg::SDCD_RD, 1'b1, r[20:19], {4'h0, col}, m, 16'h0000);
         `CHK(rdCol, col)
         `CHK(rdActive, 1'b1)
         // drive enable follows the beat by two edges, then the ctrl samples
         repeat (3) @(posedge clk);
         #1;
         `CHK(rdWord & keep(m), colWord(col) & keep(m))
      end
      $display("test reads done");
      for (i = 0; i < 10; i++) begin
         r = xs();
         m = (i == 2) ? 2'h3 : r[17:16];
         col = r[8:0];
         req(sdcd_pkg::SDCD_WR, 1'b1, r[20:19], {4'h0, col}, m, r[31:16]);
         if (m != 2'h3 && qd.size() < 8) qd.push_back({col, m, r[31:16]});
      end
      for (i = 0; i < 40; i++) begin
         @(negedge clk);
         r = xs();
         wrReady = r[0];
         // the head shown now is the beat taken at the coming edge
         if (wrValid === 1'b1 && wrReady === 1'b1) begin
            e = qd.pop_front();
            `CHK({wrCol, wrMask, wrData & keep(wrMask)}, {e[26:16], e[15:0] & keep(e[17:16])})
         end
      end
      `CHK(qd.size(), 0)
      $display("test writes done");
      req(sdcd_pkg::SDCD_PRE, 1'b1, 2'h1, 13'h0000, 2'h0, 16'h0000);
      `CHK(bankOpen, 4'hD)
      req(sdcd_pkg::SDCD_RD, 1'b1, 2'h2, 13'h0400, 2'h0, 16'h0000);
      repeat (10) @(posedge clk);
      #1;
      `CHK(bankOpen, 4'h9)
      req(sdcd_pkg::SDCD_PRE, 1'b1, 2'h0, 13'h0400, 2'h0, 16'h0000);
      `CHK(bankOpen, 4'h0)
      $display("test precharge done");
      oldRow = refreshRow;
      req(sdcd_pkg::SDCD_REF, 1'b1, 2'h3, 13'h1FFF, 2'h3, 16'h0000);
      `CHK(refreshRow !== oldRow, 1'b1)
      req(sdcd_pkg::SDCD_REF, 1'b0, 2'h0, 13'h0000, 2'h0, 16'h0000);
      `CHK(selfRefresh, 1'b1)
      req(sdcd_pkg::SDCD_NOP, 1'b1, 2'h0, 13'h0000, 2'h0, 16'h0000);
      `CHK(selfRefresh, 1'b0)
      req(sdcd_pkg::SDCD_TERM, 1'b1, 2'h0, 13'h0000, 2'h0, 16'h0000);
      `CHK(deep_sleep_mode, 1'b0)
      req(sdcd_pkg::SDCD_TERM, 1'b0, 2'h0, 13'h0000, 2'h0, 16'h0000);
      `CHK(deep_sleep_mode, 1'b1)
      req(sdcd_pkg::SDCD_NOP, 1'b1, 2'h0, 13'h0000, 2'h0, 16'h0000);
      `CHK(deep_sleep_mode, 1'b0)
      $display("test refresh and sleep done");
      complete_run;
   end
endmodule
